//--- src/input_map_params.svh
// Constants of the programmable input function map.
// Assumes APB byte addresses and a 125 MHz system clock.
`ifndef INPUT_MAP_PARAMS_SVH
`define INPUT_MAP_PARAMS_SVH
// Register byte offsets
`define OFS_FSEL_TOP 3'h0
`define OFS_CONTACT 8'h20
`define OFS_RESTART 8'h24
`define OFS_MODE 8'h28
`define OFS_TERM 8'h2C
`define OFS_FUNC 8'h30
`define RESTART_KEY 8'hA5
// Reset values: defaults of position pulse mode, terminal 8 first
`define FSEL_RST {5'h0A, 5'h03, 5'h02, 5'h01, 5'h0D, 5'h0E, 5'h0C, 5'h00}
`define CONTACT_RST 8'h00
`define MODE_RST 3'h0
// Control modes
`define MODE_PT 3'h0
`define MODE_PR 3'h1
`define MODE_SR 3'h3
// Function codes with special handling
`define FN_COUNT 23
`define FN_FAULT_CLR 1
`define FN_SPD_DIR 6
`define FN_DEV_RESET 10
`define FN_PULSE_INH 11
`define FN_PULSE_MASK 23'h300002
// Reserved codes 9 and 15 never reach the function vector
`define FN_RSVD_MASK 23'h008200
// Start-up load walks eight entries plus one for the read latency
`define LOAD_LAST 4'h8
`endif

//--- src/input_map_pkg.sv
// Types shared by the input function map modules.
// Assumes input_map_params.svh is on the include path.
package input_map_pkg;
  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN = 2'b10
  } map_state_t;
  typedef struct packed {
    map_state_t state;
    logic [3:0] idx;
    logic [7:0][4:0] fmap;
    logic [7:0] ct;
    logic [7:0] ct_set;
    logic [2:0] mode;
    logic [22:0] hit_q;
    logic [22:0] fn;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } map_regs_t;
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
  } sync_regs_t;
  typedef struct packed {
    logic [7:0][4:0] mem;
    logic [4:0] rdata;
  } store_regs_t;
endpackage

//--- src/terminal_sync.sv
// Two-stage synchroniser for the eight terminal pins.
// Assumes pins are asynchronous to sys_clk.
`timescale 1ns/100ps
module terminal_sync (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] pins,
  output logic [7:0] synced
);
  import input_map_pkg::*;
  sync_regs_t st_r;
  sync_regs_t st_nxt;
  // First stage feeds only the second stage
  always_comb begin
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign synced = st_r.s2;
endmodule

//--- src/setting_store.sv
// Eight function setting words with registered read data.
// Assumes one write and one read port are enough.
`timescale 1ns/100ps
`include "input_map_params.svh"
module setting_store (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [4:0] wdata,
  input wire logic [2:0] raddr,
  output logic [4:0] rdata
);
  import input_map_pkg::*;
  store_regs_t st_r;
  store_regs_t st_nxt;
  // Read returns the old word when read and write collide
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = st_r.mem[raddr];
    if (we) begin
      st_nxt.mem[waddr] = wdata;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_r.mem <= `FSEL_RST;
      st_r.rdata <= 5'h00;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign rdata = st_r.rdata;
endmodule

//--- src/input_function_map.sv
// Top of the programmable input function map with its APB slave.
// Assumes a single sys_clk domain and an APB master with pstrb.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "input_map_params.svh"
module input_function_map (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] prog_input_terminals,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic servo_enable_in,
  output logic fault_clear_in,
  output logic fwd_torque_limit_in,
  output logic rev_torque_limit_in,
  output logic int_speed_sel_bit0,
  output logic int_speed_sel_bit1,
  output logic int_speed_direction,
  output logic zero_speed_lock,
  output logic gain_set_select,
  output logic deviation_reset,
  output logic pulse_inhibit,
  output logic emergency_halt,
  output logic reverse_prohibit,
  output logic forward_prohibit,
  output logic pos_reg_sel_bit0,
  output logic pos_reg_sel_bit1,
  output logic pos_reg_sel_bit2,
  output logic pos_cmd_hold,
  output logic pos_reg_trigger,
  output logic home_search_trigger,
  output logic origin_sensor_in
);
  import input_map_pkg::*;

  map_regs_t st_r;
  map_regs_t st_nxt;
  logic [7:0] term_sync;
  logic [7:0] term_act;
  logic [22:0] func_hit;
  logic [22:0][7:0] match;
  logic mem_we;
  logic [2:0] mem_raddr;
  logic [4:0] mem_rdata;
  logic run;
  logic acc_first;
  logic acc_done;

  terminal_sync u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pins(prog_input_terminals),
    .synced(term_sync)
  );

  setting_store u_store (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .we(mem_we),
    .waddr(paddr[4:2]),
    .wdata(pwdata[4:0]),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // Contact type correction with the latched copy only
  assign term_act = term_sync ^ st_r.ct;
  assign run = (st_r.state == ST_RUN);

  // One match per function and terminal; unlisted codes match nothing
  for (genvar c = 0; c < `FN_COUNT; c++) begin : g_fn
    for (genvar t = 0; t < 8; t++) begin : g_term
      assign match[c][t] = term_act[t] && (st_r.fmap[t] == 5'(c));
    end
    assign func_hit[c] = run && (|match[c]);
  end

  // APB phases: first access cycle computes the answer, second completes
  assign acc_first = run && psel && penable && !st_r.pready;
  assign acc_done = psel && penable && st_r.pready;
  assign mem_we = acc_done && pwrite && pstrb[0] && !st_r.pslverr && (paddr[7:5] == `OFS_FSEL_TOP);
  // Last load cycle reads for the bus already, so a transfer held over the load gets fresh data
  assign mem_raddr = (run || (st_r.idx == `LOAD_LAST)) ? paddr[4:2] : st_r.idx[2:0];

  // Next state: start-up load, function decode and register access
  always_comb begin
    logic [31:0] rd;
    logic ok;
    logic pos_mode;
    rd = 32'h0000_0000;
    ok = 1'b1;
    pos_mode = (st_r.mode == `MODE_PT) || (st_r.mode == `MODE_PR);
    st_nxt = st_r;
    st_nxt.pready = 1'b0;
    case (st_r.state)
      ST_LOAD: begin
        // Mapping is copied from the settings only here, at start-up
        if (st_r.idx == 4'h0) begin
          st_nxt.ct = st_r.ct_set;
        end else begin
          st_nxt.fmap[st_r.idx[2:0] - 3'h1] = mem_rdata;
        end
        st_nxt.idx = st_r.idx + 4'h1;
        if (st_r.idx == `LOAD_LAST) begin
          st_nxt.state = ST_RUN;
        end
        st_nxt.hit_q = 23'h000000;
        st_nxt.fn = 23'h000000;
      end
      ST_RUN: begin
        st_nxt.hit_q = func_hit;
        // Levels pass through; trigger codes fire once on activation
        st_nxt.fn = (func_hit & ~`FN_PULSE_MASK) | (func_hit & ~st_r.hit_q & `FN_PULSE_MASK);
        st_nxt.fn = st_nxt.fn & ~`FN_RSVD_MASK;
        // Mode-qualified functions stay quiet in other modes
        if (!pos_mode) begin
          st_nxt.fn[`FN_DEV_RESET] = 1'b0;
          st_nxt.fn[`FN_PULSE_INH] = 1'b0;
        end
        if (st_r.mode != `MODE_SR) begin
          st_nxt.fn[`FN_SPD_DIR] = 1'b0;
        end
      end
      default: begin
        st_nxt.state = ST_LOAD;
        st_nxt.idx = 4'h0;
      end
    endcase
    // Read answer prepared in the first access cycle
    if (paddr[7:5] == `OFS_FSEL_TOP) begin
      rd = {27'h0000000, mem_rdata};
    end else begin
      case (paddr)
        `OFS_CONTACT: rd = {24'h000000, st_r.ct_set};
        `OFS_RESTART: rd = {31'h00000000, run};
        `OFS_MODE: rd = {29'h00000000, st_r.mode};
        `OFS_TERM: rd = {8'h00, st_r.ct, term_act, term_sync};
        `OFS_FUNC: rd = {9'h000, st_r.fn};
        default: ok = 1'b0;
      endcase
    end
    if (acc_first) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = !ok;
      st_nxt.prdata = pwrite ? 32'h0000_0000 : (ok ? rd : 32'h0000_0000);
    end
    // Writes land on the completing edge; codes and contact type wait for restart, the mode acts at once
    if (acc_done && pwrite && pstrb[0] && !st_r.pslverr) begin
      case (paddr)
        `OFS_CONTACT: st_nxt.ct_set = pwdata[7:0];
        `OFS_MODE: st_nxt.mode = pwdata[2:0];
        `OFS_RESTART: begin
          if (pwdata[7:0] == `RESTART_KEY) begin
            st_nxt.state = ST_LOAD;
            st_nxt.idx = 4'h0;
          end
        end
        default: ok = ok;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_r.state <= ST_LOAD;
      st_r.idx <= 4'h0;
      st_r.fmap <= `FSEL_RST;
      st_r.ct <= `CONTACT_RST;
      st_r.ct_set <= `CONTACT_RST;
      st_r.mode <= `MODE_RST;
      st_r.hit_q <= 23'h000000;
      st_r.fn <= 23'h000000;
      st_r.pready <= 1'b0;
      st_r.pslverr <= 1'b0;
      st_r.prdata <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Bus outputs straight from flops
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;

  // Function outputs, one flop bit per code
  assign servo_enable_in = st_r.fn[0];
  assign fault_clear_in = st_r.fn[1];
  assign fwd_torque_limit_in = st_r.fn[2];
  assign rev_torque_limit_in = st_r.fn[3];
  assign int_speed_sel_bit0 = st_r.fn[4];
  assign int_speed_sel_bit1 = st_r.fn[5];
  assign int_speed_direction = st_r.fn[6];
  assign zero_speed_lock = st_r.fn[7];
  assign gain_set_select = st_r.fn[8];
  assign deviation_reset = st_r.fn[10];
  assign pulse_inhibit = st_r.fn[11];
  assign emergency_halt = st_r.fn[12];
  assign reverse_prohibit = st_r.fn[13];
  assign forward_prohibit = st_r.fn[14];
  assign pos_reg_sel_bit0 = st_r.fn[16];
  assign pos_reg_sel_bit1 = st_r.fn[17];
  assign pos_reg_sel_bit2 = st_r.fn[18];
  assign pos_cmd_hold = st_r.fn[19];
  assign pos_reg_trigger = st_r.fn[20];
  assign home_search_trigger = st_r.fn[21];
  assign origin_sensor_in = st_r.fn[22];

  // Checks on mapping, decode and bus timing
  property p_map_frozen;
    @(posedge sys_clk) disable iff (!rstn)
    (run && $past(run)) |-> ($stable(st_r.fmap) && $stable(st_r.ct));
  endproperty
  a_map_frozen: assert property (p_map_frozen) else $error("mapping changed while running");

  property p_load_len;
    @(posedge sys_clk) disable iff (!rstn)
    (run ##1 !run) |-> (!run)[*8] ##1 (!run) ##1 run;
  endproperty
  a_load_len: assert property (p_load_len) else $error("start-up load not nine cycles");

  property p_servo;
    @(posedge sys_clk) disable iff (!rstn)
    (run && $past(run)) |-> (servo_enable_in == $past(|match[0]));
  endproperty
  a_servo: assert property (p_servo) else $error("servo enable does not follow its terminals");

  property p_clear_pulse;
    @(posedge sys_clk) disable iff (!rstn)
    fault_clear_in |-> ($past(func_hit[1]) && !$past(func_hit[1], 2)) ##1 !fault_clear_in;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("fault clear not a single activation pulse");

  property p_dev_mode;
    @(posedge sys_clk) disable iff (!rstn)
    (deviation_reset || pulse_inhibit) |-> $past((st_r.mode == `MODE_PT) || (st_r.mode == `MODE_PR));
  endproperty
  a_dev_mode: assert property (p_dev_mode) else $error("position function outside position mode");

  property p_dir_mode;
    @(posedge sys_clk) disable iff (!rstn)
    int_speed_direction |-> ($past(st_r.mode) == `MODE_SR);
  endproperty
  a_dir_mode: assert property (p_dir_mode) else $error("direction outside register speed mode");

  property p_idle_quiet;
    @(posedge sys_clk) disable iff (!rstn)
    (run && $past(term_act) == 8'h00 && $past(run)) |-> (st_r.fn == 23'h000000);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("function active without active terminal");

  property p_trig_pulse;
    @(posedge sys_clk) disable iff (!rstn)
    pos_reg_trigger |=> !pos_reg_trigger;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("position trigger longer than one cycle");

  // Two different triggers may fire on neighbouring cycles, so each is checked alone
  property p_home_pulse;
    @(posedge sys_clk) disable iff (!rstn)
    home_search_trigger |=> !home_search_trigger;
  endproperty
  a_home_pulse: assert property (p_home_pulse) else $error("home trigger longer than one cycle");

  property p_apb_wait;
    @(posedge sys_clk) disable iff (!rstn)
    (run && psel && !penable) |=> !pready ##1 pready ##1 !pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("APB answer not after one wait state");

  property p_load_quiet;
    @(posedge sys_clk) disable iff (!rstn)
    !run |=> (st_r.fn == 23'h000000);
  endproperty
  a_load_quiet: assert property (p_load_quiet) else $error("function active during start-up load");

  property p_reserved;
    @(posedge sys_clk) disable iff (!rstn)
    (st_r.fn & `FN_RSVD_MASK) == 23'h000000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code reached the function vector");

  // Plain level functions track their terminals one cycle later
  property p_torque;
    @(posedge sys_clk) disable iff (!rstn)
    (run && $past(run)) |->
      (fwd_torque_limit_in == $past(|match[2])) && (rev_torque_limit_in == $past(|match[3]));
  endproperty
  a_torque: assert property (p_torque) else $error("torque limit does not follow its terminals");

  property p_speed_sel;
    @(posedge sys_clk) disable iff (!rstn)
    (run && $past(run)) |->
      (int_speed_sel_bit0 == $past(|match[4])) && (int_speed_sel_bit1 == $past(|match[5]));
  endproperty
  a_speed_sel: assert property (p_speed_sel) else $error("speed selector does not follow its terminals");

  property p_gain;
    @(posedge sys_clk) disable iff (!rstn)
    (run && $past(run)) |-> (gain_set_select == $past(|match[8]));
  endproperty
  a_gain: assert property (p_gain) else $error("gain select does not follow its terminals");

  property p_halt;
    @(posedge sys_clk) disable iff (!rstn)
    (run && $past(run)) |-> (emergency_halt == $past(|match[12]));
  endproperty
  a_halt: assert property (p_halt) else $error("emergency halt does not follow its terminals");

  property p_prohibit;
    @(posedge sys_clk) disable iff (!rstn)
    (run && $past(run)) |->
      (reverse_prohibit == $past(|match[13])) && (forward_prohibit == $past(|match[14]));
  endproperty
  a_prohibit: assert property (p_prohibit) else $error("run prohibit does not follow its terminals");

  property p_pos_sel;
    @(posedge sys_clk) disable iff (!rstn)
    (run && $past(run)) |-> (pos_reg_sel_bit0 == $past(|match[16])) &&
      (pos_reg_sel_bit1 == $past(|match[17])) && (pos_reg_sel_bit2 == $past(|match[18]));
  endproperty
  a_pos_sel: assert property (p_pos_sel) else $error("position selector does not follow its terminals");

  property p_hold;
    @(posedge sys_clk) disable iff (!rstn)
    (run && $past(run)) |-> (pos_cmd_hold == $past(|match[19]));
  endproperty
  a_hold: assert property (p_hold) else $error("position hold does not follow its terminals");

  property p_origin;
    @(posedge sys_clk) disable iff (!rstn)
    (run && $past(run)) |-> (origin_sensor_in == $past(|match[22]));
  endproperty
  a_origin: assert property (p_origin) else $error("origin level does not follow its terminals");

  // A refused transfer must not leak stale read data
  property p_err_data;
    @(posedge sys_clk) disable iff (!rstn)
    (pready && pslverr) |-> (prdata == 32'h0000_0000);
  endproperty
  a_err_data: assert property (p_err_data) else $error("error answer carries nonzero data");

  c_servo: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(servo_enable_in));
  c_restart: cover property (@(posedge sys_clk) disable iff (!rstn) run ##1 !run);
  c_home: cover property (@(posedge sys_clk) disable iff (!rstn) home_search_trigger);
  c_trig: cover property (@(posedge sys_clk) disable iff (!rstn) pos_reg_trigger);
  c_err: cover property (@(posedge sys_clk) disable iff (!rstn) pready && pslverr);
endmodule

//--- test/contact_bank.sv
// Model of the switches, sensors or PLC outputs wired to the eight terminals.
// Assumes the bench tells it which contacts are closed; high pin = contact closed.
`timescale 1ns/100ps
module contact_bank (
  input wire logic [7:0] closed,
  output logic [7:0] pins
);
  // Clean contacts: no bounce modelled, the synchroniser sees steady levels
  assign pins = closed;
endmodule

//--- test/programmable_input_function_map_bench.sv
// Self-checking bench for the input function map: APB tasks plus terminal stimulus.
// Assumes the design sources and contact_bank are compiled first.
`timescale 1ns/100ps
module programmable_input_function_map_bench;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] closed = 8'h00;
  logic [7:0] pins;
  logic [31:0] prdata, rd, fn_vec;
  logic pready, pslverr, err;
  logic servo_enable_in, fault_clear_in, fwd_torque_limit_in, rev_torque_limit_in;
  logic int_speed_sel_bit0, int_speed_sel_bit1, int_speed_direction, zero_speed_lock;
  logic gain_set_select, deviation_reset, pulse_inhibit, emergency_halt, reverse_prohibit;
  logic forward_prohibit, pos_reg_sel_bit0, pos_reg_sel_bit1, pos_reg_sel_bit2, pos_cmd_hold;
  logic pos_reg_trigger, home_search_trigger, origin_sensor_in;
  int cycles = 0;
  int bad_count = 0;
  int compares = 0;
  logic [4:0] dflt [8] = '{5'h00, 5'h0C, 5'h0E, 5'h0D, 5'h01, 5'h02, 5'h03, 5'h0A};
  int ml [4] = '{0, 3, 1, 2};

  always #4 sys_clk = ~sys_clk;

  contact_bank sw (.closed(closed), .pins(pins));
  input_function_map uut (.sys_clk, .rstn, .prog_input_terminals(pins), .paddr, .psel, .penable,
    .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .servo_enable_in, .fault_clear_in,
    .fwd_torque_limit_in, .rev_torque_limit_in, .int_speed_sel_bit0, .int_speed_sel_bit1,
    .int_speed_direction, .zero_speed_lock, .gain_set_select, .deviation_reset, .pulse_inhibit,
    .emergency_halt, .reverse_prohibit, .forward_prohibit, .pos_reg_sel_bit0, .pos_reg_sel_bit1,
    .pos_reg_sel_bit2, .pos_cmd_hold, .pos_reg_trigger, .home_search_trigger, .origin_sensor_in);

  // Function outputs gathered by code number; codes 9 and 15 have no output
  assign fn_vec = {9'h000, origin_sensor_in, home_search_trigger, pos_reg_trigger, pos_cmd_hold,
    pos_reg_sel_bit2, pos_reg_sel_bit1, pos_reg_sel_bit0, 1'b0, forward_prohibit, reverse_prohibit,
    emergency_halt, pulse_inhibit, deviation_reset, 1'b0, gain_set_select, zero_speed_lock,
    int_speed_direction, int_speed_sel_bit1, int_speed_sel_bit0, rev_torque_limit_in,
    fwd_torque_limit_in, fault_clear_in, servo_enable_in};

  task final_report();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Cuts a hang short; the full run needs well under 5000 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only pready or the bench timeout ends this wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Key write reloads the mapping; the status read waits out the load
  task restart();
    apb(1'b1, 8'h24, 32'h000000A5);
    apb(1'b0, 8'h24, 32'h0);
    chk(rd & 32'h1, 32'h1);
  endtask

  // Outputs follow a pin change at the third edge: two sync stages plus the output flop
  task set_pins(input logic [7:0] v);
    @(posedge sys_clk);
    closed <= v;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic [31:0] fexp(input int c, input int m);
    if (c > 22 || c == 9 || c == 15) return 32'h0;
    if (c == 6 && m != 3) return 32'h0;
    if ((c == 10 || c == 11) && m > 1) return 32'h0;
    return 32'h1 << c;
  endfunction

  initial begin
    int code;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    // Reset settings, then an unmapped place
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, {27'h0, dflt[i]});
    end
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // Byte lane 0 off: the mode write must be dropped
    pstrb <= 4'h0;
    apb(1'b1, 8'h28, 32'h5);
    pstrb <= 4'hF;
    apb(1'b0, 8'h28, 32'h0);
    chk(rd, 32'h0);
    // Default mapping in Pt mode, fault clear terminal left open
    set_pins(8'hEF);
    chk(fn_vec, 32'h0000740D);
    set_pins(8'h00);
    // New code and contact type stay dormant until the restart
    apb(1'b1, 8'h20, 32'h01);
    apb(1'b1, 8'h00, 32'h0C);
    set_pins(8'h00);
    chk(fn_vec, 32'h0);
    restart();
    set_pins(8'h00);
    chk(fn_vec, 32'h00001000);
    set_pins(8'h01);
    chk(fn_vec, 32'h0);
    apb(1'b1, 8'h20, 32'h00);
    // Two terminals sharing code 0
    apb(1'b1, 8'h00, 32'h00);
    apb(1'b1, 8'h1C, 32'h00);
    restart();
    set_pins(8'h80);
    chk(fn_vec, 32'h1);
    set_pins(8'h81);
    chk(fn_vec, 32'h1);
    set_pins(8'h01);
    chk(fn_vec, 32'h1);
    set_pins(8'h00);
    chk(fn_vec, 32'h0);
    // Codes 0 to 22 and unlisted code 31 on a rotating terminal, in Pt, Sr, Pr and Sz mode
    foreach (ml[k]) begin
      apb(1'b1, 8'h28, 32'(ml[k]));
      for (int c = 0; c < 24; c++) begin
        code = (c == 23) ? 31 : c;
        apb(1'b1, 8'(4 * (c % 8)), 32'(code));
        restart();
        set_pins(8'h01 << (c % 8));
        chk(fn_vec, fexp(code, ml[k]));
        @(posedge sys_clk);
        #1;
        chk(fn_vec, fexp(code, ml[k]) & 32'h00CFFFFD);
        set_pins(8'h00);
      end
    end
    final_report();
  end
endmodule
